// ===== rtl/crc_regs_pkg.sv
package crc_regs_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int CRC_W = 16;
  localparam int COUNT_W = 5;
  localparam logic [COUNT_W-1:0] SHIFT_STEPS = 5'h10;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 5'h00;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_INPUT_LOW = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_INPUT_HIGH = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_RESULT_LOW = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_RESULT_HIGH = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_SHIFT_LOW = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_SHIFT_HIGH = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_POLY_LOW = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_POLY_HIGH = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int STATUS_BUSY_BIT = 0;
  localparam int POLY_CONST_BIT = 0;
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [CRC_W-1:0] WORD_RESET = 16'h0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_type;

  typedef enum logic [0:0] {
    SHIFT_IDLE,
    SHIFT_RUN
  } shift_state_type;

endpackage

// ===== rtl/crc_shift_engine.sv
`timescale 1ns/10ps
module crc_shift_engine
#(
  parameter int WIDTH = crc_regs_pkg::CRC_W
)
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic load, // Load strobe for the shifter
  input wire logic [WIDTH-1:0] load_word, // Word to load
  input wire logic [WIDTH-1:0] result_now, // Current result value
  input wire logic [WIDTH-1:0] poly_terms, // Term enables, bit 0 ignored
  output logic [WIDTH-1:0] shifter, // Shifter contents
  output logic [WIDTH-1:0] result_step, // Result after one step
  output logic step, // High while a step is taken
  output logic busy // Shifting in progress
);

  // ----------------------------------------------------------------
  // Shift state
  // ----------------------------------------------------------------
  crc_regs_pkg::shift_state_type state;
  logic [crc_regs_pkg::COUNT_W-1:0] count;
  wire feedback;
  wire [WIDTH-1:0] poly_full;
  wire last_step;

  assign step = (state == crc_regs_pkg::SHIFT_RUN);
  assign busy = step;
  assign last_step = (count == crc_regs_pkg::SHIFT_STEPS - 5'h01);
  assign feedback = shifter[WIDTH-1] ^ result_now[WIDTH-1];
  assign poly_full = {poly_terms[WIDTH-1:1], 1'b1};

  // ----------------------------------------------------------------
  // Feedback network
  // ----------------------------------------------------------------
  assign result_step[0] = feedback;
  genvar i;
  generate
    for (i = 1; i < WIDTH; i++)
    begin : g_tap
      assign result_step[i] = result_now[i-1] ^ (feedback & poly_full[i]);
    end
  endgenerate

  // A new load restarts the count, so a late write is never half mixed
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= crc_regs_pkg::SHIFT_IDLE;
      count <= crc_regs_pkg::COUNT_ZERO;
      shifter <= crc_regs_pkg::WORD_RESET;
    end
    else if (load)
    begin
      state <= crc_regs_pkg::SHIFT_RUN;
      count <= crc_regs_pkg::COUNT_ZERO;
      shifter <= load_word;
    end
    else
    begin
      case (state)
        crc_regs_pkg::SHIFT_IDLE:
        begin
          count <= crc_regs_pkg::COUNT_ZERO;
        end
        crc_regs_pkg::SHIFT_RUN:
        begin
          shifter <= {shifter[WIDTH-2:0], 1'b0};
          count <= count + 5'h01;
          if (last_step)
          begin
            state <= crc_regs_pkg::SHIFT_IDLE;
          end
        end
        default:
        begin
          state <= crc_regs_pkg::SHIFT_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== rtl/crc_register_interface.sv
`timescale 1ns/10ps
module crc_register_interface
(
  input wire logic clk, // System clock, 40 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [crc_regs_pkg::ADDR_W-1:0] addr, // Register address
  input wire logic [crc_regs_pkg::DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [crc_regs_pkg::DATA_W-1:0] rdata, // Read data, next cycle
  output logic shift_busy // Shifter still stepping
);

  // ----------------------------------------------------------------
  // Request bundle and decoding
  // ----------------------------------------------------------------
  crc_regs_pkg::bus_req_type req;

  assign req.wr = wr;
  assign req.rd = rd;
  assign req.addr = addr;
  assign req.wdata = wdata;

  function automatic logic hit
  (
    input crc_regs_pkg::bus_req_type r,
    input logic [crc_regs_pkg::ADDR_W-1:0] off
  );
    hit = (r.addr == off);
  endfunction

  wire wr_input_low;
  wire wr_input_high;
  wire wr_result_low;
  wire wr_result_high;
  wire wr_poly_low;
  wire wr_poly_high;

  assign wr_input_low = req.wr & hit(req, crc_regs_pkg::OFF_INPUT_LOW);
  assign wr_input_high = req.wr & hit(req, crc_regs_pkg::OFF_INPUT_HIGH);
  assign wr_result_low = req.wr & hit(req, crc_regs_pkg::OFF_RESULT_LOW);
  assign wr_result_high = req.wr & hit(req, crc_regs_pkg::OFF_RESULT_HIGH);
  assign wr_poly_low = req.wr & hit(req, crc_regs_pkg::OFF_POLY_LOW);
  assign wr_poly_high = req.wr & hit(req, crc_regs_pkg::OFF_POLY_HIGH);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [crc_regs_pkg::DATA_W-1:0] crc_input_high;
  logic [crc_regs_pkg::DATA_W-1:0] crc_input_low;
  logic [crc_regs_pkg::DATA_W-1:0] crc_result_high;
  logic [crc_regs_pkg::DATA_W-1:0] crc_result_low;
  logic [crc_regs_pkg::DATA_W-1:0] crc_poly_terms_high;
  logic [crc_regs_pkg::DATA_W-1:1] crc_poly_terms_low;

  wire [crc_regs_pkg::CRC_W-1:0] input_word;
  wire [crc_regs_pkg::CRC_W-1:0] load_word;
  wire [crc_regs_pkg::CRC_W-1:0] running_result;
  wire [crc_regs_pkg::CRC_W-1:0] poly_terms;
  wire [crc_regs_pkg::CRC_W-1:0] shifter;
  wire [crc_regs_pkg::CRC_W-1:0] result_step;
  wire step;
  wire busy;

  assign input_word = {crc_input_high, crc_input_low};
  assign running_result = {crc_result_high, crc_result_low};
  assign poly_terms = {crc_poly_terms_high, crc_poly_terms_low, 1'b0};

  // The low byte write carries its own data straight to the shifter, so
  // the load sees the new byte in the same cycle it is written
  assign load_word = {crc_input_high, req.wdata};

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  crc_shift_engine #(
    .WIDTH(crc_regs_pkg::CRC_W)
  ) u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .load(wr_input_low),
    .load_word(load_word),
    .result_now(running_result),
    .poly_terms(poly_terms),
    .shifter(shifter),
    .result_step(result_step),
    .step(step),
    .busy(busy)
  );

  assign shift_busy = busy;

  // ----------------------------------------------------------------
  // Input word
  // ----------------------------------------------------------------
  // Reset value is arbitrary to software; zero keeps the state defined
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc_input_high <= crc_regs_pkg::BYTE_RESET;
      crc_input_low <= crc_regs_pkg::BYTE_RESET;
    end
    else
    begin
      if (wr_input_high)
      begin
        crc_input_high <= req.wdata;
      end
      if (wr_input_low)
      begin
        crc_input_low <= req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Running result
  // ----------------------------------------------------------------
  // A software write to a byte beats a shift step on that byte; the
  // other byte still takes the step, so software should write only
  // while the shifter is idle
  wire [crc_regs_pkg::DATA_W-1:0] next_result_high;
  wire [crc_regs_pkg::DATA_W-1:0] next_result_low;

  assign next_result_high = wr_result_high ? req.wdata :
                            step ? result_step[15:8] :
                            crc_result_high;
  assign next_result_low = wr_result_low ? req.wdata :
                           step ? result_step[7:0] :
                           crc_result_low;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc_result_high <= crc_regs_pkg::BYTE_RESET;
      crc_result_low <= crc_regs_pkg::BYTE_RESET;
    end
    else
    begin
      crc_result_high <= next_result_high;
      crc_result_low <= next_result_low;
    end
  end

  // ----------------------------------------------------------------
  // Polynomial term enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc_poly_terms_high <= crc_regs_pkg::BYTE_RESET;
      crc_poly_terms_low <= crc_regs_pkg::BYTE_RESET[7:1];
    end
    else
    begin
      if (wr_poly_high)
      begin
        crc_poly_terms_high <= req.wdata;
      end
      if (wr_poly_low)
      begin
        crc_poly_terms_low <= req.wdata[7:1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Shifter bytes have no write decode at all, so writes there vanish
  logic [crc_regs_pkg::DATA_W-1:0] read_mux;
  logic [crc_regs_pkg::DATA_W-1:0] status_byte;
  logic [crc_regs_pkg::DATA_W-1:0] next_rdata;

  always_comb
  begin
    status_byte = crc_regs_pkg::BYTE_ZERO;
    status_byte[crc_regs_pkg::STATUS_BUSY_BIT] = busy;
  end

  always_comb
  begin
    case (req.addr)
      crc_regs_pkg::OFF_INPUT_LOW:
        read_mux = crc_input_low;
      crc_regs_pkg::OFF_INPUT_HIGH:
        read_mux = crc_input_high;
      crc_regs_pkg::OFF_RESULT_LOW:
        read_mux = crc_result_low;
      crc_regs_pkg::OFF_RESULT_HIGH:
        read_mux = crc_result_high;
      crc_regs_pkg::OFF_SHIFT_LOW:
        read_mux = shifter[7:0];
      crc_regs_pkg::OFF_SHIFT_HIGH:
        read_mux = shifter[15:8];
      crc_regs_pkg::OFF_POLY_LOW:
        read_mux = {crc_poly_terms_low, 1'b0};
      crc_regs_pkg::OFF_POLY_HIGH:
        read_mux = crc_poly_terms_high;
      crc_regs_pkg::OFF_STATUS:
        read_mux = status_byte;
      default:
        read_mux = crc_regs_pkg::BYTE_ZERO;
    endcase
  end

  // Data stands only in the cycle after the strobe, zero otherwise
  assign next_rdata = req.rd ? read_mux : crc_regs_pkg::BYTE_ZERO;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= crc_regs_pkg::BYTE_ZERO;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

endmodule

// ===== verif/crc_register_interface_chk.sv
`timescale 1ns/10ps
module crc_register_interface_chk
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic [crc_regs_pkg::ADDR_W-1:0] addr, // Register address
  input wire logic [crc_regs_pkg::DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [crc_regs_pkg::DATA_W-1:0] rdata, // Read data
  input wire logic shift_busy // Shifter stepping
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  wire load = wr && addr == crc_regs_pkg::OFF_INPUT_LOW;

  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  // Sixteen edges with no reload: the steps of one load
  sequence quiet_s;
    (!load)[*8] ##1 (!load)[*8];
  endsequence

  sequence busy_s;
    shift_busy[*8] ##1 shift_busy[*8];
  endsequence

  // A step landing between write and read would change the result
  property back_p(logic [3:0] a);
    wr && addr == a && !shift_busy && !$past(load) ##1 rd && addr == a
      |=> rdata == $past(wdata, 2);
  endproperty

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  busy_after_load_a: assert property (load |=> busy_s)
    else $error("shifter stopped before sixteen steps");
  busy_ends_a: assert property (load ##1 quiet_s |=> !shift_busy)
    else $error("shifter still busy after sixteen steps");
  read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside the answer cycle");
  input_back_a: assert property (back_p(4'h1))
    else $error("input high byte readback wrong");
  result_low_a: assert property (back_p(4'h2))
    else $error("result low byte readback wrong");
  result_high_a: assert property (back_p(4'h3))
    else $error("result high byte readback wrong");
  poly_high_a: assert property (back_p(4'h7))
    else $error("poly high byte readback wrong");
  poly_bit0_a: assert property ($past(rd) && $past(addr) == 4'h6
    |-> rdata[0] == 1'b0)
    else $error("poly bit zero read as one");
  shift_idle_a: assert property (rd && addr[3:1] == 3'b010
    && !shift_busy && !$past(load) |=> rdata == 8'h00)
    else $error("idle shifter not empty");
endmodule

bind crc_register_interface crc_register_interface_chk u_chk (.clk(clk),
  .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .shift_busy(shift_busy));

// ===== verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;}
    row_type;
  typedef struct packed {logic [15:0] p; logic [15:0] r; logic [15:0] w;}
    run_type;
  logic clk;
  logic rst_n;
  logic [crc_regs_pkg::ADDR_W-1:0] addr;
  logic [crc_regs_pkg::DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [crc_regs_pkg::DATA_W-1:0] rdata;
  logic shift_busy;
  int errors;
  int compares;
  int cycles;
  int n;
  logic [7:0] v;
  logic [7:0] hi;
  row_type rows [9];
  run_type runs [3];

  crc_register_interface u_crc_register_interface (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .shift_busy(shift_busy));

  // ----------------------------------------------------------------
  // Bus tasks and reference
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [3:0] a,
    input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask

  // Read data only stand in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] q);
    bus(1'b0, 1'b1, a, 8'h00);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
    @(posedge clk);
  endtask

  function automatic logic [15:0] model(input logic [15:0] p,
    input logic [15:0] r, input logic [15:0] w);
    logic fb;
    for (int i = 0; i < 16; i++)
    begin
      fb = w[15] ^ r[15];
      r = {r[14:0], 1'b0} ^ (fb ? (p | 16'h0001) : 16'h0000);
      w = {w[14:0], 1'b0};
    end
    return r;
  endfunction

  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    rows = '{'{4'h1, 8'hA5, 8'hA5}, '{4'h2, 8'h5A, 8'h5A},
      '{4'h3, 8'hC3, 8'hC3}, '{4'h7, 8'h81, 8'h81}, '{4'h6, 8'hFF, 8'hFE},
      '{4'h4, 8'hFF, 8'h00}, '{4'h5, 8'hFF, 8'h00}, '{4'h8, 8'hFF, 8'h00},
      '{4'h9, 8'h77, 8'h00}};
    runs = '{'{16'h1021, 16'hFFFF, 16'h1234},
      '{16'h0000, 16'h0000, 16'h8001}, '{16'h8005, 16'h1234, 16'hFFFF}};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 10; a++)
    begin
      rd_reg(a[3:0], v);
      check("reset value", {8'h00, v}, 16'h0000);
    end
    // Write then read back with no gap, reserved places included
    foreach (rows[i])
    begin
      bus(1'b1, 1'b0, rows[i].a, rows[i].d);
      rd_reg(rows[i].a, v);
      check("readback", {8'h00, v}, {8'h00, rows[i].e});
    end
    foreach (runs[i])
    begin
      bus(1'b1, 1'b0, 4'h7, runs[i].p[15:8]);
      bus(1'b1, 1'b0, 4'h6, runs[i].p[7:0]);
      bus(1'b1, 1'b0, 4'h3, runs[i].r[15:8]);
      bus(1'b1, 1'b0, 4'h2, runs[i].r[7:0]);
      bus(1'b1, 1'b0, 4'h1, runs[i].w[15:8]);
      bus(1'b1, 1'b0, 4'h0, runs[i].w[7:0]);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      rd_reg(4'h8, v);
      check("busy after load", {8'h00, v}, 16'h0001);
      // Sixteen steps from the load edge; the idle cycle and the status read took three
      n = 0;
      repeat (40)
      begin
        @(negedge clk);
        if (shift_busy !== 1'b1)
          break;
        n++;
      end
      check("busy length", n[15:0], 16'h000D);
      check("busy low", {15'h0000, shift_busy}, 16'h0000);
      @(posedge clk);
      rd_reg(4'h2, v);
      rd_reg(4'h3, hi);
      check("result", {hi, v}, model(runs[i].p, runs[i].r, runs[i].w));
      rd_reg(4'h5, hi);
      rd_reg(4'h4, v);
      check("shifter drained", {hi, v}, 16'h0000);
    end
    // Second reset while the shifter runs must stop it and clear the result and the shifter
    bus(1'b1, 1'b0, 4'h0, 8'h3C);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("busy after reset", {15'h0000, shift_busy}, 16'h0000);
    @(posedge clk);
    rd_reg(4'h2, v);
    rd_reg(4'h3, hi);
    check("result after reset", {hi, v}, 16'h0000);
    rd_reg(4'h5, hi);
    rd_reg(4'h4, v);
    check("shifter after reset", {hi, v}, 16'h0000);
    stop_test();
  end
endmodule
